// [pbm_onchip_model.sv]
// partner model: the on-chip adc, timer, serial controller, lin layer and pwm
// assumes the bench hands it one stimulus word and holds it steady per step
`timescale 1ns/1ps

module pbm_onchip_model
    import pbm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] stim,
    output logic [PIN_COUNT-1:0] adc_select,
    output logic [PIN_COUNT-1:0] timer_select,
    output logic [PIN_COUNT-1:0] timer_out,
    output logic [PIN_COUNT-1:0] timer_out_en,
    output logic sci_txd,
    output logic lin_phy_rxd,
    output logic pwm_channel_0,
    output logic pwm_channel_1
);
    // ****************************************
    // module drives
    // ****************************************
    // modules own selection
    // selects are thinned so lower priority levels win often enough
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_select <= 3'h0;
            timer_select <= 3'h0;
            timer_out <= 3'h0;
            timer_out_en <= 3'h0;
            sci_txd <= 1'b1;
            lin_phy_rxd <= 1'b1;
            pwm_channel_0 <= 1'b0;
            pwm_channel_1 <= 1'b0;
        end else begin
            adc_select <= stim[2:0] & stim[21:19];
            timer_select <= stim[5:3] & stim[24:22];
            timer_out <= stim[8:6];
            timer_out_en <= stim[11:9];
            sci_txd <= stim[12];
            lin_phy_rxd <= stim[13];
            pwm_channel_0 <= stim[14];
            pwm_channel_1 <= stim[15];
        end
    end
endmodule // pbm_onchip_model

// [pbm_pin_sel.sv]
// one pin: picks the winning function and its drive
// assumes requests and drives come from logic on the same clock
`timescale 1ns/1ps

module pbm_pin_sel
    import pbm_pkg::*;
(
    input wire logic adc_req,
    input wire logic tim_req,
    input wire logic alt_req,
    input wire pbm_drive_type tim_drv,
    input wire pbm_drive_type alt_drv,
    input wire pbm_drive_type gpio_drv,
    input wire logic pue,
    output pbm_drive_type drv,
    output logic pullup_on,
    output pbm_level_type level
);

    // ****************************************
    // priority pick
    // ****************************************
    always_comb begin
        if (adc_req) begin
            level = LVL_ANALOG;
            drv = '{out: 1'b0, oe: 1'b0};
        end else if (tim_req) begin
            level = LVL_TIMER;
            drv = tim_drv;
        end else if (alt_req) begin
            level = LVL_ALT;
            drv = alt_drv;
        end else begin
            level = LVL_GPIO;
            drv = gpio_drv;
        end
    end

    // ddr output direction kills pull-up, even when timer or alternate wins; analog pins never see it
    assign pullup_on = pue && !gpio_drv.oe && (level != LVL_ANALOG);

endmodule // pbm_pin_sel

// [pbm_pkg.sv]
// constants, types and address decode for the port pin multiplexer
// assumes a 32-bit AXI4-Lite register bus with word-indexed registers

package pbm_pkg;

    // ****************************************
    // bus and map
    // ****************************************
    localparam int ADDR_W = 14;
    localparam int PIN_COUNT = 3;
    localparam logic [11:0] BLK_BASE_IDX = 12'h200;
    localparam logic [11:0] NB_BASE_IDX = 12'h300;
    localparam logic [11:0] CFG1_IDX = 12'h020;
    localparam logic [11:0] CFG2_IDX = 12'h021;
    localparam logic [11:0] DATA_IDX = 12'h022;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int PUE_LSB = 4;
    localparam int DDR_LSB = 0;
    localparam int PWM_SEL_BIT = 3;
    localparam int PWM_EN_BIT = 2;
    localparam int SER_LSB = 0;
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [2:0] DATA_RST = 3'h0;
    localparam logic [7:0] CFG1_MASK = 8'h77;
    localparam logic [7:0] CFG2_MASK = 8'h0F;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        SER_INTERNAL = 2'b00,
        SER_EXT_SCI = 2'b01,
        SER_EXT_LIN = 2'b10,
        SER_OBSERVE = 2'b11
    } pbm_ser_mode_type;

    typedef enum logic [1:0] {
        LVL_ANALOG = 2'b00,
        LVL_TIMER = 2'b01,
        LVL_ALT = 2'b10,
        LVL_GPIO = 2'b11
    } pbm_level_type;

    typedef enum logic [1:0] {
        REG_CFG1 = 2'b00,
        REG_CFG2 = 2'b01,
        REG_DATA = 2'b10,
        REG_NONE = 2'b11
    } pbm_reg_type;

    typedef struct packed {
        logic out;
        logic oe;
    } pbm_drive_type;

    // both bases alias the same three registers
    function automatic pbm_reg_type pbm_decode(input logic [ADDR_W-1:0] addr);
        logic [11:0] idx;
        idx = addr[ADDR_W-1:2];
        if (idx == BLK_BASE_IDX + CFG1_IDX || idx == NB_BASE_IDX + CFG1_IDX) begin
            return REG_CFG1;
        end else if (idx == BLK_BASE_IDX + CFG2_IDX || idx == NB_BASE_IDX + CFG2_IDX) begin
            return REG_CFG2;
        end else if (idx == BLK_BASE_IDX + DATA_IDX || idx == NB_BASE_IDX + DATA_IDX) begin
            return REG_DATA;
        end else begin
            return REG_NONE;
        end
    endfunction

endpackage

// [pbm_port_mux.sv]
// port pin multiplexer top with its AXI4-Lite register slave
// assumes pins are asynchronous and on-chip modules share aclk
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module pbm_port_mux
    import pbm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [PIN_COUNT-1:0] port_pin_in,
    output logic [PIN_COUNT-1:0] port_pin_out,
    output logic [PIN_COUNT-1:0] port_pin_oe,
    output logic [PIN_COUNT-1:0] port_pin_pullup,
    input wire logic [PIN_COUNT-1:0] adc_select,
    input wire logic [PIN_COUNT-1:0] timer_select,
    input wire logic [PIN_COUNT-1:0] timer_out,
    input wire logic [PIN_COUNT-1:0] timer_out_en,
    output logic [PIN_COUNT-1:0] timer_capture_in,
    input wire logic sci_txd,
    output logic sci_rxd,
    input wire logic lin_phy_rxd,
    output logic lin_phy_txd,
    input wire logic pwm_channel_0,
    input wire logic pwm_channel_1
);

    // ****************************************
    // state
    // ****************************************
    logic [7:0] cfg1_r;
    logic [7:0] cfg2_r;
    logic [2:0] data_r;
    logic [PIN_COUNT-1:0] pin_meta_r;
    logic [PIN_COUNT-1:0] pin_sync_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_strb_r;
    logic wr_fire;
    pbm_reg_type wr_reg;
    pbm_reg_type rd_reg;
    logic [2:0] pue;
    logic [2:0] ddr;
    logic pwm_sel;
    logic pwm_en;
    pbm_ser_mode_type ser_mode;
    logic [PIN_COUNT-1:0] alt_req;
    pbm_drive_type alt_drv [PIN_COUNT];
    pbm_drive_type pin_drv [PIN_COUNT];
    pbm_level_type level [PIN_COUNT];
    logic [PIN_COUNT-1:0] pullup_nxt;
    logic sci_rxd_nxt;
    logic lin_txd_nxt;
    logic [2:0] rd_port;
    logic [PIN_COUNT-1:0] pin_out_r;
    logic [PIN_COUNT-1:0] pin_oe_r;
    logic [PIN_COUNT-1:0] pin_pullup_r;
    logic [PIN_COUNT-1:0] tim_cap_r;
    logic sci_rxd_r;
    logic lin_txd_r;

    assign pue = cfg1_r[PUE_LSB +: 3];
    assign ddr = cfg1_r[DDR_LSB +: 3];
    assign pwm_sel = cfg2_r[PWM_SEL_BIT];
    assign pwm_en = cfg2_r[PWM_EN_BIT];
    assign ser_mode = pbm_ser_mode_type'(cfg2_r[SER_LSB +: 2]);

    // ****************************************
    // pin synchroniser
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= port_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    // one write in flight; bvalid one edge after both halves are taken
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;
    assign wr_reg = pbm_decode(aw_addr_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
        end else begin
            if (awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready_r) begin
                wready_r <= 1'b0;
                w_data_r <= wdata[7:0];
                w_strb_r <= wstrb[0];
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                // unmapped words answer with an error
                bresp_r <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // configuration and data registers
    // ****************************************
    // reserved bits are masked on write so they always read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg1_r <= CFG1_RST;
            cfg2_r <= CFG2_RST;
            data_r <= DATA_RST;
        end else if (wr_fire && w_strb_r) begin
            // both bases reach the same word
            if (wr_reg == REG_CFG1) begin
                cfg1_r <= w_data_r & CFG1_MASK;
            end else if (wr_reg == REG_CFG2) begin
                cfg2_r <= w_data_r & CFG2_MASK;
            end else if (wr_reg == REG_DATA) begin
                data_r <= w_data_r[2:0];
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    assign rd_reg = pbm_decode(araddr);
    // outputs read back the latch, inputs the synced pin
    assign rd_port = (ddr & data_r) | (~ddr & pin_sync_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            if (arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rresp_r <= RESP_OKAY;
                if (rd_reg == REG_CFG1) begin
                    rdata_r <= {24'h00_0000, cfg1_r};
                end else if (rd_reg == REG_CFG2) begin
                    rdata_r <= {24'h00_0000, cfg2_r};
                end else if (rd_reg == REG_DATA) begin
                    rdata_r <= {29'h0000_0000, rd_port};
                end else begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= RESP_SLVERR;
                end
            end
            if (rvalid_r && rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // alternate function requests and drives
    // ****************************************
    // serial/PWM requested by the routing fields themselves
    assign alt_req = {pwm_en, {2{ser_mode != SER_INTERNAL}}};

    always_comb begin
        alt_drv[0] = '{out: 1'b0, oe: 1'b0};
        alt_drv[1] = '{out: 1'b0, oe: 1'b0};
        alt_drv[2] = '{out: pwm_sel ? pwm_channel_1 : pwm_channel_0, oe: 1'b1};
        case (ser_mode)
            SER_EXT_SCI: begin
                alt_drv[1] = '{out: sci_txd, oe: 1'b1};
            end
            SER_EXT_LIN: begin
                // lin receive out on pin 0
                alt_drv[0] = '{out: lin_phy_rxd, oe: 1'b1};
            end
            SER_OBSERVE: begin
                // both pins mirror the inside link
                alt_drv[0] = '{out: lin_phy_rxd, oe: 1'b1};
                alt_drv[1] = '{out: sci_txd, oe: 1'b1};
            end
            default: begin
            end
        endcase
    end

    // ****************************************
    // serial and LIN inside routing
    // ****************************************
    // a pin lost to a higher function feeds idle high, never a stale level
    always_comb begin
        sci_rxd_nxt = 1'b1;
        lin_txd_nxt = 1'b1;
        case (ser_mode)
            SER_INTERNAL, SER_OBSERVE: begin
                // serial talks to the LIN layer inside
                sci_rxd_nxt = lin_phy_rxd;
                lin_txd_nxt = sci_txd;
            end
            SER_EXT_SCI: begin
                sci_rxd_nxt = (level[0] == LVL_ALT) ? pin_sync_r[0] : 1'b1;
            end
            SER_EXT_LIN: begin
                lin_txd_nxt = (level[1] == LVL_ALT) ? pin_sync_r[1] : 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ****************************************
    // per pin priority
    // ****************************************
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        pbm_pin_sel u_sel (
            .adc_req(adc_select[i]),
            .tim_req(timer_select[i]),
            .alt_req(alt_req[i]),
            .tim_drv({timer_out[i], timer_out_en[i]}),
            .alt_drv(alt_drv[i]),
            // plain output takes the data bit
            .gpio_drv({data_r[i], ddr[i]}),
            .pue(pue[i]),
            .drv(pin_drv[i]),
            .pullup_on(pullup_nxt[i]),
            .level(level[i])
        );
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
            pin_pullup_r <= '0;
            tim_cap_r <= '0;
            sci_rxd_r <= 1'b1;
            lin_txd_r <= 1'b1;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                pin_out_r[i] <= pin_drv[i].out;
                pin_oe_r[i] <= pin_drv[i].oe;
            end
            pin_pullup_r <= pullup_nxt;
            tim_cap_r <= pin_sync_r;
            sci_rxd_r <= sci_rxd_nxt;
            lin_txd_r <= lin_txd_nxt;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign port_pin_out = pin_out_r;
    assign port_pin_oe = pin_oe_r;
    assign port_pin_pullup = pin_pullup_r;
    assign timer_capture_in = tim_cap_r;
    assign sci_rxd = sci_rxd_r;
    assign lin_phy_txd = lin_txd_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_both_taken;
        awvalid && awready_r && wvalid && wready_r;
    endsequence

    sequence s_ar_taken;
        arvalid && arready_r;
    endsequence

    property p_analog_first;
        adc_select[0] |=> !pin_oe_r[0] && !pin_pullup_r[0];
    endproperty
    a_analog_first: assert property (p_analog_first) else $error("analog pin still driven");

    property p_timer_over_alt;
        !adc_select[1] && timer_select[1] |=> pin_oe_r[1] == $past(timer_out_en[1]);
    endproperty
    a_timer_over_alt: assert property (p_timer_over_alt) else $error("timer lost pin 1");

    property p_pullup_off;
        ddr[0] |=> !pin_pullup_r[0];
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on an output");

    property p_gpio_drive;
        !adc_select[2] && !timer_select[2] && !pwm_en && ddr[2]
            |=> pin_oe_r[2] && pin_out_r[2] == $past(data_r[2]);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) else $error("pin 2 not driven from data");

    property p_pwm_route;
        !adc_select[2] && !timer_select[2] && pwm_en
            |=> pin_oe_r[2] && pin_out_r[2] == $past(pwm_sel ? pwm_channel_1 : pwm_channel_0);
    endproperty
    a_pwm_route: assert property (p_pwm_route) else $error("pwm channel not on pin 2");

    property p_internal_link;
        ser_mode == SER_INTERNAL |=> sci_rxd_r == $past(lin_phy_rxd) && lin_txd_r == $past(sci_txd);
    endproperty
    a_internal_link: assert property (p_internal_link) else $error("inside link broken");

    property p_ext_sci;
        ser_mode == SER_EXT_SCI && !adc_select[1] && !timer_select[1]
            |=> pin_oe_r[1] && pin_out_r[1] == $past(sci_txd);
    endproperty
    a_ext_sci: assert property (p_ext_sci) else $error("serial transmit not on pin 1");

    property p_ext_lin;
        ser_mode == SER_EXT_LIN && !adc_select[0] && !timer_select[0]
            |=> pin_oe_r[0] && pin_out_r[0] == $past(lin_phy_rxd);
    endproperty
    a_ext_lin: assert property (p_ext_lin) else $error("lin receive not on pin 0");

    property p_observe;
        ser_mode == SER_OBSERVE && adc_select[1:0] == 2'b00 && timer_select[1:0] == 2'b00
            |=> pin_oe_r[1:0] == 2'b11 && lin_txd_r == $past(sci_txd);
    endproperty
    a_observe: assert property (p_observe) else $error("observe mode pins not driven");

    property p_write_answer;
        s_both_taken |=> !bvalid_r ##1 bvalid_r;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer late");

    property p_read_data;
        s_ar_taken ##0 (pbm_decode(araddr) == REG_DATA)
            |=> rvalid_r && rdata_r[2:0] == $past(rd_port) && rdata_r[31:3] == '0;
    endproperty
    a_read_data: assert property (p_read_data) else $error("data read wrong");

endmodule // pbm_port_mux

// [testbench.sv]
// self-checking bench for the port pin multiplexer
// assumes the on-chip partner model and a pin world driving stim[18:16] when undriven
`timescale 1ns/1ps

module testbench
    import pbm_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, stim = '0, seed = 32'h00007D42;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, sci_txd, sci_rxd, lin_phy_rxd, lin_phy_txd, pwm0, pwm1;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] pin_in, pin_out, pin_oe, pin_pu, adc, tsel, tout, toen, cap;
    logic [2:0] e_out, e_oe, e_pu, e_pin, win;
    logic e_srx, e_ltx;
    int mismatches = 0, checked = 0;

    // ****************************************
    // clock, pins, instances
    // ****************************************
    initial begin
        forever #50 aclk = ~aclk;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & stim[18:16]);
    pbm_port_mux i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe(pin_oe),
        .port_pin_pullup(pin_pu), .adc_select(adc), .timer_select(tsel), .timer_out(tout),
        .timer_out_en(toen), .timer_capture_in(cap), .sci_txd(sci_txd), .sci_rxd(sci_rxd),
        .lin_phy_rxd(lin_phy_rxd), .lin_phy_txd(lin_phy_txd), .pwm_channel_0(pwm0), .pwm_channel_1(pwm1));
    pbm_onchip_model i_onchip (.aclk(aclk), .aresetn(aresetn), .stim(stim), .adc_select(adc),
        .timer_select(tsel), .timer_out(tout), .timer_out_en(toen), .sci_txd(sci_txd),
        .lin_phy_rxd(lin_phy_rxd), .pwm_channel_0(pwm0), .pwm_channel_1(pwm1));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    function automatic logic [ADDR_W-1:0] ba(input logic [11:0] base, input logic [11:0] off);
        return {base + off, 2'b00};
    endfunction

    task automatic summarize();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t bus got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [2:0] got, input logic [2:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t pin got %h expected %h", $time, got, exp);
        end
    endtask

    // master holds each channel until its own ready; the answer ends the wait
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                n = 1000;
            end
        end
        if (n != 1000) mismatches++;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        d = 32'hFFFFFFFF;
        r = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                n = 1000;
            end
        end
        if (n != 1000) mismatches++;
    endtask

    // reference model of one settled configuration
    task automatic predict(input logic [7:0] c1, input logic [7:0] c2, input logic [2:0] dv);
        logic [1:0] m;
        m = c2[1:0];
        for (int i = 0; i < 3; i++) begin
            win[i] = 1'b0;
            e_pu[i] = c1[4 + i] & ~c1[i] & ~(stim[i] & stim[19 + i]);
            if (stim[i] & stim[19 + i]) begin
                e_oe[i] = 1'b0;
                e_out[i] = 1'b0;
            end else if (stim[3 + i] & stim[22 + i]) begin
                e_oe[i] = stim[9 + i];
                e_out[i] = stim[6 + i];
            end else if (i == 2 && c2[2]) begin
                e_oe[i] = 1'b1;
                e_out[i] = c2[3] ? stim[15] : stim[14];
            end else if (i < 2 && m != 2'b00) begin
                win[i] = 1'b1;
                e_oe[i] = (i == 0) ? (m != 2'b01) : (m != 2'b10);
                e_out[i] = (i == 0) ? stim[13] : stim[12];
            end else begin
                e_oe[i] = c1[i];
                e_out[i] = dv[i];
            end
            e_out[i] = e_out[i] & e_oe[i];
            e_pin[i] = e_oe[i] ? e_out[i] : stim[16 + i];
        end
        e_srx = (m == 2'b01) ? (win[0] ? e_pin[0] : 1'b1) : (m == 2'b10) ? 1'b1 : stim[13];
        e_ltx = (m == 2'b10) ? (win[1] ? e_pin[1] : 1'b1) : (m == 2'b01) ? 1'b1 : stim[12];
    endtask

    // ****************************************
    // watchdog
    // ****************************************
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        summarize();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        logic [7:0] c1, c2;
        logic [2:0] dv;
        logic [11:0] offs [3];
        logic [11:0] bases [2];
        offs = '{CFG1_IDX, CFG2_IDX, DATA_IDX};
        bases = '{BLK_BASE_IDX, NB_BASE_IDX};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (bases[b]) begin
            foreach (offs[o]) begin
                rd(ba(bases[b], offs[o]), d, r);
                cmp_bus(d, 32'h00000000);
                cmp_bus({30'h0, r}, {30'h0, RESP_OKAY});
            end
        end
        wr(ba(NB_BASE_IDX, CFG1_IDX), 8'hFF, 4'hF, r);
        wr(ba(NB_BASE_IDX, CFG2_IDX), 8'hFF, 4'hF, r);
        rd(ba(BLK_BASE_IDX, CFG1_IDX), d, r);
        cmp_bus(d, 32'h00000077);
        rd(ba(BLK_BASE_IDX, CFG2_IDX), d, r);
        cmp_bus(d, 32'h0000000F);
        wr(ba(BLK_BASE_IDX, CFG1_IDX), 8'h00, 4'h0, r);
        rd(ba(NB_BASE_IDX, CFG1_IDX), d, r);
        cmp_bus(d, 32'h00000077);
        wr({12'h123, 2'b00}, 8'h55, 4'hF, r);
        cmp_bus({30'h0, r}, {30'h0, RESP_SLVERR});
        rd({12'h123, 2'b00}, d, r);
        cmp_bus(d, 32'h00000000);
        cmp_bus({30'h0, r}, {30'h0, RESP_SLVERR});
        for (int k = 0; k < 48; k++) begin
            seed = xs(seed);
            c1 = seed[7:0];
            seed = xs(seed);
            c2 = {seed[7:2], k[1:0]};
            dv = seed[10:8];
            seed = xs(seed);
            stim <= seed;
            wr(ba(BLK_BASE_IDX, CFG1_IDX), c1, 4'hF, r);
            wr(ba(NB_BASE_IDX, CFG2_IDX), c2, 4'h1, r);
            wr(ba(BLK_BASE_IDX, DATA_IDX), {5'h00, dv}, 4'hF, r);
            repeat (4) @(posedge aclk);
            predict(c1, c2, dv);
            cmp_pin(pin_oe, e_oe);
            cmp_pin(pin_out & e_oe, e_out);
            cmp_pin(pin_pu, e_pu);
            cmp_pin({1'b0, sci_rxd, lin_phy_txd}, {1'b0, e_srx, e_ltx});
            cmp_pin(cap, e_pin);
            rd(ba(NB_BASE_IDX, DATA_IDX), d, r);
            cmp_bus(d, {29'h0, (c1[2:0] & dv) | (~c1[2:0] & e_pin)});
        end
        summarize();
    end
endmodule // testbench
